// [abu_params.svh]
// constants of the address breakpoint unit: offsets, fields, resets, vectors
`ifndef ABU_PARAMS_SVH
`define ABU_PARAMS_SVH

// ----------------------------------------------------------------------
// register offsets
// ----------------------------------------------------------------------
`define ABU_ADDR_W            8
`define ABU_OFF_STATUS_CTRL   8'h00
`define ABU_OFF_ADDR_HIGH     8'h01
`define ABU_OFF_ADDR_LOW      8'h02
`define ABU_OFF_FLAG_CTRL     8'h03

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ABU_BIT_ARM           7
`define ABU_BIT_ACTIVE        6
`define ABU_BIT_FLAG_CLR_EN   7

// ----------------------------------------------------------------------
// reset values and vectors
// ----------------------------------------------------------------------
`define ABU_RST_BYTE          8'h00
`define ABU_RST_WORD          16'h0000
`define ABU_VEC_USER          16'hFFFC
`define ABU_VEC_MONITOR       16'hFEFC

`endif

// [abu_pkg.sv]
// types shared by the address breakpoint unit
`default_nettype none
`include "abu_params.svh"

package abu_pkg;

   // ----------------------------------------------------------------------
   // break sequencing states
   // ----------------------------------------------------------------------
   typedef enum logic [1:0] {
      ST_IDLE,
      ST_PENDING,
      ST_IN_BREAK
   } abu_state_e_t;

   // ----------------------------------------------------------------------
   // register port request
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [`ABU_ADDR_W-1:0] addr;
      logic [7:0]             wdata;
      logic                   wr;
      logic                   rd;
   } abu_bus_req_t;

   // ----------------------------------------------------------------------
   // cpu and integration unit status
   // ----------------------------------------------------------------------
   typedef struct packed {
      logic [15:0] addr;
      logic        from_pc;
      logic        swi_loaded;
      logic        rti_exec;
      logic        monitor_mode;
      logic        wait_mode;
      logic        stop_mode;
   } abu_cpu_t;

   // ----------------------------------------------------------------------
   // complete state of the unit
   // ----------------------------------------------------------------------
   typedef struct packed {
      abu_state_e_t st;
      logic         arm;
      logic         active;
      logic         suppress;
      logic [7:0]   addr_hi;
      logic [7:0]   addr_lo;
      logic         flag_clr_en;
      logic [7:0]   rd_data;
      logic [15:0]  vector;
      logic         tv_s1;
      logic         tv_s2;
   } abu_regs_t;

endpackage

`default_nettype wire

// [abu_match.sv]
// address comparator of the address breakpoint unit
`timescale 1ns/10ps
`default_nettype none

module abu_match
(
   input  wire logic [15:0] cpu_addr_in,
   input  wire logic [15:0] break_addr_in,
   input  wire logic        arm_in,
   input  wire logic        from_pc_in,
   input  wire logic        low_power_in,
   output logic             hit_out
);

   // ----------------------------------------------------------------------
   // qualified full 16-bit compare
   // ----------------------------------------------------------------------
   // data accesses never count, only program counter addresses
   // the bus is frozen in wait and stop, so no hit there
   assign hit_out = arm_in && from_pc_in && !low_power_in
                    && (cpu_addr_in == break_addr_in);

endmodule

`default_nettype wire

// [abu_top.sv]
// address breakpoint unit: registers, break sequencing and side controls
// --------------------------------------------------------------------------
// --------------------------------------------------------------------------
//
// Added by the designer: the address map and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
`include "abu_params.svh"

module abu_top
(
   input  wire logic                 clk_in,
   input  wire logic                 arst_n_in,
   input  wire abu_pkg::abu_bus_req_t bus_in,
   output logic [7:0]                rd_data_out,
   input  wire abu_pkg::abu_cpu_t    cpu_in,
   input  wire logic                 test_voltage_in,
   output logic                      breakpoint_request_out,
   output logic                      software_trap_instr_out,
   output logic [15:0]               vector_addr_out,
   output logic                      in_break_out,
   output logic                      timer_halt_out,
   output logic                      watchdog_disable_out,
   output logic                      flag_clear_allowed_out
);

   // ----------------------------------------------------------------------
   // state and decode
   // ----------------------------------------------------------------------
   abu_pkg::abu_regs_t r_r;
   abu_pkg::abu_regs_t r_nxt;
   logic               hit;
   logic               wr_scr;
   logic               wr_hi;
   logic               wr_lo;
   logic               wr_fcr;
   logic               sw_set;
   logic               sw_clr;
   logic [7:0]         rd_mux;

   assign wr_scr = bus_in.wr && (bus_in.addr == `ABU_OFF_STATUS_CTRL);
   assign wr_hi  = bus_in.wr && (bus_in.addr == `ABU_OFF_ADDR_HIGH);
   assign wr_lo  = bus_in.wr && (bus_in.addr == `ABU_OFF_ADDR_LOW);
   assign wr_fcr = bus_in.wr && (bus_in.addr == `ABU_OFF_FLAG_CTRL);
   assign sw_set = wr_scr && bus_in.wdata[`ABU_BIT_ACTIVE];
   assign sw_clr = wr_scr && !bus_in.wdata[`ABU_BIT_ACTIVE];

   // ----------------------------------------------------------------------
   // comparator
   // ----------------------------------------------------------------------
   // a hit already taken stays blocked until an address byte is rewritten
   abu_match u_match
   (
      .cpu_addr_in   (cpu_in.addr),
      .break_addr_in ({r_r.addr_hi, r_r.addr_lo}),
      .arm_in        (r_r.arm && !r_r.active && !r_r.suppress),
      .from_pc_in    (cpu_in.from_pc),
      .low_power_in  (cpu_in.wait_mode || cpu_in.stop_mode),
      .hit_out       (hit)
   );

   // ----------------------------------------------------------------------
   // read multiplexer
   // ----------------------------------------------------------------------
   always_comb
   begin
      unique case (bus_in.addr)
         `ABU_OFF_STATUS_CTRL: rd_mux = {r_r.arm, r_r.active, 6'h00};
         `ABU_OFF_ADDR_HIGH:   rd_mux = r_r.addr_hi;
         `ABU_OFF_ADDR_LOW:    rd_mux = r_r.addr_lo;
         `ABU_OFF_FLAG_CTRL:   rd_mux = {r_r.flag_clr_en, 7'h00};
         default:              rd_mux = 8'h00;
      endcase
   end

   // ----------------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------------
   always_comb
   begin
      r_nxt = r_r;
      // test voltage arrives from a pin, two stages before use
      r_nxt.tv_s1 = test_voltage_in;
      r_nxt.tv_s2 = r_r.tv_s1;
      // read data stand for exactly the cycle after the strobe
      r_nxt.rd_data = bus_in.rd ? rd_mux : 8'h00;
      // vector follows the mode so it is ready when the trap fetches it
      r_nxt.vector = cpu_in.monitor_mode ? `ABU_VEC_MONITOR : `ABU_VEC_USER;

      if (wr_scr)
      begin
         r_nxt.arm = bus_in.wdata[`ABU_BIT_ARM];
      end
      if (wr_hi)
      begin
         r_nxt.addr_hi = bus_in.wdata;
      end
      if (wr_lo)
      begin
         r_nxt.addr_lo = bus_in.wdata;
      end
      if (wr_fcr)
      begin
         r_nxt.flag_clr_en = bus_in.wdata[`ABU_BIT_FLAG_CLR_EN];
      end

      // a rewritten address frees the comparator for the next break
      if (wr_hi || wr_lo)
      begin
         r_nxt.suppress = 1'b0;
      end

      // software clear first, so a hit in the same cycle wins
      if (sw_clr)
      begin
         r_nxt.active = 1'b0;
      end
      if (hit || sw_set)
      begin
         r_nxt.active = 1'b1;
      end
      if (hit)
      begin
         // same address keeps matching after exit; block it
         r_nxt.suppress = 1'b1;
      end

      unique case (r_r.st)
         abu_pkg::ST_IDLE:
         begin
            if (hit || sw_set)
            begin
               r_nxt.st = abu_pkg::ST_PENDING;
            end
         end
         abu_pkg::ST_PENDING:
         begin
            // held until the integration unit has substituted the trap
            if (cpu_in.swi_loaded)
            begin
               r_nxt.st = abu_pkg::ST_IN_BREAK;
            end
         end
         abu_pkg::ST_IN_BREAK:
         begin
            if (cpu_in.rti_exec)
            begin
               r_nxt.st = abu_pkg::ST_IDLE;
            end
         end
      endcase
   end

   // ----------------------------------------------------------------------
   // state register
   // ----------------------------------------------------------------------
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         r_r.st          <= abu_pkg::ST_IDLE;
         r_r.arm         <= 1'b0;
         r_r.active      <= 1'b0;
         r_r.suppress    <= 1'b0;
         r_r.addr_hi     <= `ABU_RST_BYTE;
         r_r.addr_lo     <= `ABU_RST_BYTE;
         r_r.flag_clr_en <= 1'b0;
         r_r.rd_data     <= `ABU_RST_BYTE;
         r_r.vector      <= `ABU_VEC_USER;
         r_r.tv_s1       <= 1'b0;
         r_r.tv_s2       <= 1'b0;
      end
      else
      begin
         r_r <= r_nxt;
      end
   end

   // ----------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------
   // the live hit joins the request so an opcode fetch is caught at the
   // boundary in front of it; an operand hit waits for the next boundary
   assign breakpoint_request_out = (r_r.st == abu_pkg::ST_PENDING)
                                   || ((r_r.st == abu_pkg::ST_IDLE) && hit);
   assign software_trap_instr_out = breakpoint_request_out && cpu_in.swi_loaded;
   assign vector_addr_out        = r_r.vector;
   assign rd_data_out            = r_r.rd_data;
   assign in_break_out           = (r_r.st == abu_pkg::ST_IN_BREAK);
   assign timer_halt_out         = in_break_out;
   assign watchdog_disable_out   = in_break_out && r_r.tv_s2;
   assign flag_clear_allowed_out = !in_break_out || r_r.flag_clr_en;

   // ----------------------------------------------------------------------
   // assertions
   // ----------------------------------------------------------------------
   default clocking cb @(posedge clk_in);
   endclocking
   default disable iff (!arst_n_in);

   sequence s_pending_wait;
      (r_r.st == abu_pkg::ST_PENDING) && !cpu_in.swi_loaded;
   endsequence

   sequence s_enter_break;
      (r_r.st == abu_pkg::ST_PENDING) && cpu_in.swi_loaded;
   endsequence

   match_request_a : assert property (
      (r_r.st == abu_pkg::ST_IDLE) && hit |-> breakpoint_request_out
         ##1 (r_r.st == abu_pkg::ST_PENDING) && r_r.active)
      else $error("address hit did not raise the request");

   pc_only_a : assert property (
      (r_r.st == abu_pkg::ST_IDLE) && !cpu_in.from_pc && !sw_set
         |=> (r_r.st == abu_pkg::ST_IDLE))
      else $error("non program counter address caused a break");

   vector_mode_a : assert property (
      s_enter_break |=> in_break_out
         && (vector_addr_out == ($past(cpu_in.monitor_mode) ? 16'hFEFC : 16'hFFFC)))
      else $error("wrong break vector for the mode");

   arm_write_a : assert property (
      wr_scr |=> (r_r.arm == $past(bus_in.wdata[7])))
      else $error("arm bit not taken from bit seven");

   active_hit_a : assert property (
      hit |=> r_r.active [*1] ##0 breakpoint_request_out)
      else $error("hit did not set the active bit");

   soft_break_a : assert property (
      (r_r.st == abu_pkg::ST_IDLE) && sw_set |=> breakpoint_request_out && r_r.active)
      else $error("software break request lost");

   hold_request_a : assert property (
      s_pending_wait |=> breakpoint_request_out)
      else $error("request dropped before trap was loaded");

   rti_exit_a : assert property (
      in_break_out && cpu_in.rti_exec |=> !in_break_out ##0 !timer_halt_out)
      else $error("return did not end the break");

   no_rebreak_a : assert property (
      r_r.suppress && !wr_hi && !wr_lo && !sw_set && (r_r.st == abu_pkg::ST_IDLE)
         |=> (r_r.st == abu_pkg::ST_IDLE))
      else $error("break repeated on an unchanged address");

   low_power_a : assert property (
      (cpu_in.wait_mode || cpu_in.stop_mode) && !wr_scr
         && (r_r.st == abu_pkg::ST_IDLE) |=> $stable(r_r.arm)
         && (r_r.st == abu_pkg::ST_IDLE))
      else $error("break or disarm during a low power mode");

   watchdog_off_a : assert property (
      in_break_out && $past(test_voltage_in, 3) && $past(test_voltage_in, 2)
         && $stable(in_break_out) |-> watchdog_disable_out)
      else $error("watchdog left running under test voltage");

   read_slot_a : assert property (
      bus_in.rd && (bus_in.addr == `ABU_OFF_ADDR_LOW) && !wr_lo
         |=> (rd_data_out == r_r.addr_lo))
      else $error("read data not in the following cycle");

   halt_in_break_a : assert property (
      s_enter_break |=> timer_halt_out)
      else $error("timer not halted on break entry");

   flag_gate_a : assert property (
      in_break_out && !r_r.flag_clr_en |-> !flag_clear_allowed_out)
      else $error("flag clearing allowed in break while disabled");

   flag_free_a : assert property (
      !in_break_out |-> flag_clear_allowed_out)
      else $error("flag clearing blocked outside break");

   addr_high_a : assert property (
      wr_hi |=> (r_r.addr_hi == $past(bus_in.wdata)))
      else $error("high address byte not written");

   addr_low_a : assert property (
      wr_lo |=> (r_r.addr_lo == $past(bus_in.wdata)))
      else $error("low address byte not written");

   sw_clear_a : assert property (
      sw_clr && !hit |=> !r_r.active)
      else $error("active bit not cleared by software");

   watchdog_on_a : assert property (
      !in_break_out |-> !watchdog_disable_out)
      else $error("watchdog disabled outside a break");

endmodule

`default_nettype wire

// [abu_cpu_model.sv]
// integration unit model: loads the trap instruction at an instruction boundary
`timescale 1ns/10ps
`default_nettype none

module abu_cpu_model
(
   input  wire logic       clk_in,
   input  wire logic       arst_n_in,
   input  wire logic       request_in,
   input  wire logic [1:0] delay_in,
   output logic            trap_load_out
);
   // ----------------------------------------------------------------------
   // boundary wait, then a one-cycle load pulse
   // ----------------------------------------------------------------------
   logic [1:0] wait_r;

   // delay_in stands for a long instruction; the request must hold meanwhile
   always_ff @(posedge clk_in or negedge arst_n_in)
   begin
      if (!arst_n_in)
      begin
         wait_r        <= 2'h0;
         trap_load_out <= 1'b0;
      end
      else if (trap_load_out)
      begin
         wait_r        <= 2'h0;
         trap_load_out <= 1'b0;
      end
      else if (request_in)
      begin
         if (wait_r == delay_in)
            trap_load_out <= 1'b1;
         else
            wait_r <= wait_r + 2'h1;
      end
      else
         wait_r <= 2'h0;
   end
endmodule
`default_nettype wire

// [abu_top_bench.sv]
// self-checking bench of the address breakpoint unit
`timescale 1ns/10ps
`default_nettype none

module abu_top_bench;
   // ----------------------------------------------------------------------
   // stimulus and design hookup
   // ----------------------------------------------------------------------
   logic                  clk_in;
   logic                  arst_n_in;
   abu_pkg::abu_bus_req_t bus;
   abu_pkg::abu_cpu_t     cpu;
   abu_pkg::abu_cpu_t     cpu_w;
   logic                  test_voltage_in;
   logic [1:0]            dly;
   logic                  trap_load;
   logic [7:0]            rd_data_out;
   logic                  breakpoint_request_out;
   logic                  software_trap_instr_out;
   logic [15:0]           vector_addr_out;
   logic                  in_break_out;
   logic                  timer_halt_out;
   logic                  watchdog_disable_out;
   logic                  flag_clear_allowed_out;
   int                    failures;
   int                    checked;
   int                    cycles;
   int unsigned           seed;
   int                    i;
   logic [15:0]           a;
   logic [7:0]            v;
   logic [3:0]            neg [4];

   always_comb
   begin
      cpu_w            = cpu;
      cpu_w.swi_loaded = trap_load;
   end

   abu_top i_abu_top (.clk_in(clk_in), .arst_n_in(arst_n_in), .bus_in(bus),
      .rd_data_out(rd_data_out), .cpu_in(cpu_w), .test_voltage_in(test_voltage_in),
      .breakpoint_request_out(breakpoint_request_out),
      .software_trap_instr_out(software_trap_instr_out),
      .vector_addr_out(vector_addr_out), .in_break_out(in_break_out),
      .timer_halt_out(timer_halt_out), .watchdog_disable_out(watchdog_disable_out),
      .flag_clear_allowed_out(flag_clear_allowed_out));

   abu_cpu_model i_abu_cpu_model (.clk_in(clk_in), .arst_n_in(arst_n_in),
      .request_in(breakpoint_request_out), .delay_in(dly), .trap_load_out(trap_load));

   // ----------------------------------------------------------------------
   // helpers
   // ----------------------------------------------------------------------
   function automatic logic [15:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed[15:0];
   endfunction

   task automatic end_sim();
      if (failures == 0 && checked > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask

   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checked++;
      if (got !== exp)
      begin
         failures++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic wr(input logic [7:0] ad, input logic [7:0] d);
      @(posedge clk_in);
      bus <= '{addr: ad, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge clk_in);
      bus.wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd_chk(input logic [7:0] ad, input logic [7:0] exp);
      @(posedge clk_in);
      bus <= '{addr: ad, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge clk_in);
      bus.rd <= 1'b0;
      #1;
      chk(rd_data_out, exp);
   endtask

   task automatic wait_break();
      logic seen;
      seen = 1'b0;
      for (int n = 0; n < 8 && in_break_out !== 1'b1; n++)
      begin
         @(posedge clk_in);
         #1;
         if (software_trap_instr_out === 1'b1)
            seen = 1'b1;
      end
      chk(in_break_out, 1'b1);
      chk(seen, 1'b1);
   endtask

   task automatic return_from_interrupt_instr();
      @(posedge clk_in);
      cpu.rti_exec <= 1'b1;
      @(posedge clk_in);
      cpu.rti_exec <= 1'b0;
      #1;
      chk(in_break_out, 1'b0);
      chk(timer_halt_out, 1'b0);
   endtask

   // ----------------------------------------------------------------------
   // clock and hang guard
   // ----------------------------------------------------------------------
   initial
   begin
      clk_in = 1'b0;
      forever #10 clk_in = ~clk_in;
   end

   // every scenario is short; a few thousand cycles is ample
   always @(posedge clk_in)
   begin
      cycles++;
      if (cycles == 5000)
      begin
         failures++;
         end_sim();
      end
   end

   // ----------------------------------------------------------------------
   // scenarios
   // ----------------------------------------------------------------------
   initial
   begin
      arst_n_in = 1'b0;
      bus = '0;
      cpu = '0;
      test_voltage_in = 1'b0;
      dly = 2'h0;
      failures = 0;
      checked = 0;
      cycles = 0;
      seed = 30082;
      neg = '{4'b1000, 4'b1110, 4'b1101, 4'b0100};
      repeat (8) @(posedge clk_in);
      arst_n_in <= 1'b1;
      #1;
      chk(vector_addr_out, 16'hFFFC);
      chk(flag_clear_allowed_out, 1'b1);
      for (i = 0; i < 4; i++)
         rd_chk(i[7:0], 8'h00);
      a = xs();
      wr(8'h01, a[15:8]);
      wr(8'h02, a[7:0]);
      rd_chk(8'h01, a[15:8]);
      rd_chk(8'h02, a[7:0]);
      v = 8'(xs()) | 8'h04;
      wr(v, 8'hFF);
      rd_chk(v, 8'h00);
      v = 8'(xs()) & 8'hBF;
      wr(8'h00, v);
      rd_chk(8'h00, v & 8'h80);
      // bits: arm, from program counter, wait, stop; none may break
      for (i = 0; i < 4; i++)
      begin
         wr(8'h00, {neg[i][3], 7'h00});
         @(posedge clk_in);
         cpu.addr <= a;
         cpu.from_pc <= neg[i][2];
         cpu.wait_mode <= neg[i][1];
         cpu.stop_mode <= neg[i][0];
         repeat (2) @(posedge clk_in);
         #1;
         chk(breakpoint_request_out, 1'b0);
         rd_chk(8'h00, {neg[i][3], 7'h00});
         @(posedge clk_in);
         cpu <= '0;
      end
      for (i = 0; i < 2; i++)
      begin
         // park the bus off the program counter while the address is re-aimed
         @(posedge clk_in);
         cpu.from_pc <= 1'b0;
         dly <= 2'(xs());
         test_voltage_in <= i[0];
         cpu.monitor_mode <= i[0];
         wr(8'h03, {i[0], 7'h00});
         a = xs();
         wr(8'h01, a[15:8]);
         wr(8'h02, a[7:0]);
         wr(8'h00, 8'h80);
         @(posedge clk_in);
         cpu.addr <= a;
         cpu.from_pc <= 1'b1;
         #1;
         chk(breakpoint_request_out, 1'b1);
         wait_break();
         chk(vector_addr_out, i[0] ? 16'hFEFC : 16'hFFFC);
         chk(timer_halt_out, 1'b1);
         chk(flag_clear_allowed_out, i[0]);
         repeat (2) @(posedge clk_in);
         #1;
         chk(watchdog_disable_out, i[0]);
         rd_chk(8'h00, 8'hC0);
         wr(8'h00, 8'h80);
         cpu.addr <= ~a;
         return_from_interrupt_instr();
         @(posedge clk_in);
         cpu.addr <= a;
         repeat (3) @(posedge clk_in);
         #1;
         chk(breakpoint_request_out, 1'b0);
      end
      @(posedge clk_in);
      cpu <= '0;
      wr(8'h00, 8'h40);
      #1;
      chk(breakpoint_request_out, 1'b1);
      wait_break();
      wr(8'h00, 8'h00);
      return_from_interrupt_instr();
      rd_chk(8'h00, 8'h00);
      end_sim();
   end
endmodule
`default_nettype wire
